/* spd_pkg.sv */
package spd_pkg;
    // select byte fields
    localparam int TYPE_LSB = 4;
    localparam int SEL_LSB = 1;
    localparam int RW_BIT = 0;
    localparam logic [3:0] MEM_TYPE = 4'hA;
    localparam logic [3:0] CFG_TYPE = 4'h6;
    // select codes of the configuration commands
    localparam logic [2:0] SEL_BLK0 = 3'h1;
    localparam logic [2:0] SEL_BLK1 = 3'h4;
    localparam logic [2:0] SEL_BLK2 = 3'h5;
    localparam logic [2:0] SEL_BLK3 = 3'h0;
    localparam logic [2:0] SEL_CLR = 3'h3;
    localparam logic [2:0] SEL_PAGE_LO = 3'h6;
    localparam logic [2:0] SEL_PAGE_HI = 3'h7;
    // geometry
    localparam int PAGE_BYTES = 16;
    localparam int MEM_BYTES = 512;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int WRITE_TIME_NS = 5000;
    localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int QUARTER_CYCLES = 8;
    // host registers
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam int CMD_START_BIT = 8;
    localparam int CMD_STOP_BIT = 9;
    localparam int CMD_READ_BIT = 10;
    localparam int CMD_MACK_BIT = 11;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_CMD = 3'b001,
        PH_ADDR = 3'b010,
        PH_WDATA = 3'b011,
        PH_RDATA = 3'b100,
        PH_SKIP = 3'b101
    } spd_phase_t;

    typedef enum logic [1:0] {
        OP_MEM = 2'b00,
        OP_PSET = 2'b01,
        OP_PCLR = 2'b10
    } spd_op_t;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_START = 2'b01,
        H_BIT = 2'b10,
        H_STOP = 2'b11
    } spd_hstate_t;

    // block select field to {valid, block index}
    function automatic logic [2:0] spd_blk_decode(input logic [2:0] sel);
        logic [2:0] r;
        r = 3'h0;
        if (sel == SEL_BLK0) r = 3'h4;
        else if (sel == SEL_BLK1) r = 3'h5;
        else if (sel == SEL_BLK2) r = 3'h6;
        else if (sel == SEL_BLK3) r = 3'h7;
        return r;
    endfunction : spd_blk_decode
endpackage : spd_pkg

/* spd_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface spd_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;
    // open-drain data line, pulled up when nobody drives low
    assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
    modport dev(input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host(output scl, input sda, output host_sda_o, output host_sda_oe);
endinterface : spd_if
`default_nettype wire

/* spd_dev.sv */
// Functional notes
// - select byte msb first: type, select, flag
// - memory commands need select equal to address
// - protect set/clear decoded with high voltage
// - protect query uses flag 1, any level
// - page select and query codes decoded
// - page bit picks memory half
// - page query acks only on page 0
// - write acks select then address byte
// - write cycle only on tenth-slot stop
// - busy device ignores the whole bus
// - counter advances per write unless protected
// - protected byte write is not acknowledged
// - sixteen bytes per page, wrapping inside
// - master sends one to sixteen bytes
// - protected page write nacked, nothing written
// - busy device nacks polling select bytes
// - reads ignore write protection
// - counter advances after each read byte
// - random read is dummy write plus restart
// - current read uses internal counter
// - config commands ignore the select address
// - blocks are page halves of 128 bytes
// - page resets to zero, protection persists
`timescale 1ns/100ps
`default_nettype none
module spd_dev #(
    parameter int WRITE_CYCLES = spd_pkg::WRITE_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // two-wire link
    spd_if.dev bus,
    // select pins
    input wire logic [2:0] sa_pins,
    input wire logic sa0_high_voltage,
    // protection maintenance
    input wire logic protect_erase,
    // status
    output logic write_busy,
    output logic page_sel
);
    localparam int BW = $clog2(WRITE_CYCLES + 1);

    if (WRITE_CYCLES <= spd_pkg::PAGE_BYTES) begin : g_bad_cycles
        $error("write cycle too short to commit a page");
    end

    logic [5:0] pin_s1, pin_s2, pin_s3, pin_f;
    logic scl_q, sda_q;
    spd_pkg::spd_phase_t phase_reg;
    spd_pkg::spd_op_t op_reg;
    logic [3:0] cnt_reg;
    logic [7:0] sh_reg, tx_reg, addr_reg;
    logic [4:0] wbase_reg;
    logic [1:0] blk_reg;
    logic [15:0] wmask_reg;
    logic oe_reg, page_reg, data_ok_reg, busy_reg;
    logic [BW-1:0] busy_cnt_reg;
    logic [3:0] prot_reg;
    logic [7:0] mem_arr [0:spd_pkg::MEM_BYTES-1];
    logic [7:0] wbuf [0:spd_pkg::PAGE_BYTES-1];

    // three-stage sampling of pins
    always_ff @(posedge aclk) begin
        pin_s1 <= {bus.scl, bus.sda, sa0_high_voltage, sa_pins};
        pin_s2 <= pin_s1;
        pin_s3 <= pin_s2;
    end

    // a change counts when stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_f <= 6'h30;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            pin_f <= (pin_s3 & ~(pin_s2 ^ pin_s3)) | (pin_f & (pin_s2 ^ pin_s3));
            scl_q <= pin_f[5];
            sda_q <= pin_f[4];
        end
    end

    // line events
    wire logic scl_f = pin_f[5];
    wire logic sda_f = pin_f[4];
    wire logic hv = pin_f[3];
    wire logic [2:0] logical_serial_address = pin_f[2:0];
    wire logic scl_rise = scl_f && !scl_q;
    wire logic scl_fall = !scl_f && scl_q;
    wire logic start_det = scl_f && scl_q && sda_q && !sda_f;
    wire logic stop_det = scl_f && scl_q && !sda_q && sda_f;

    // select byte decode
    wire logic [3:0] dtype = sh_reg[spd_pkg::TYPE_LSB +: 4];
    wire logic [2:0] sel = sh_reg[spd_pkg::SEL_LSB +: 3];
    wire logic rw = sh_reg[spd_pkg::RW_BIT];
    wire logic [2:0] blk_dec = spd_pkg::spd_blk_decode(sel);
    wire logic [1:0] blk_idx = blk_dec[1:0];
    wire logic blk_prot = prot_reg[blk_idx];
    wire logic is_mem = (dtype == spd_pkg::MEM_TYPE) && (sel == logical_serial_address);
    wire logic is_cfg = (dtype == spd_pkg::CFG_TYPE);
    wire logic c_mrd = is_mem && rw;
    wire logic c_mwr = is_mem && !rw;
    wire logic c_pset = is_cfg && !rw && blk_dec[2] && hv;
    wire logic c_pclr = is_cfg && !rw && (sel == spd_pkg::SEL_CLR) && hv;
    wire logic c_pq = is_cfg && rw && blk_dec[2];
    wire logic c_plo = is_cfg && !rw && (sel == spd_pkg::SEL_PAGE_LO);
    wire logic c_phi = is_cfg && !rw && (sel == spd_pkg::SEL_PAGE_HI);
    wire logic c_pgq = is_cfg && rw && (sel == spd_pkg::SEL_PAGE_LO);

    // acknowledge decisions
    wire logic cmd_ack = c_mrd || c_mwr || c_pclr || c_plo || c_phi
        || ((c_pset || c_pq) && !blk_prot)
        || (c_pgq && !page_reg);
    wire spd_pkg::spd_phase_t cmd_next = c_mrd ? spd_pkg::PH_RDATA
        : (c_mwr || c_pclr || (c_pset && !blk_prot)) ? spd_pkg::PH_ADDR
        : spd_pkg::PH_SKIP;
    wire logic wr_prot = prot_reg[{page_reg, addr_reg[7]}];
    wire logic data_acc = (op_reg != spd_pkg::OP_MEM) || !wr_prot;
    wire logic ack_now = (phase_reg == spd_pkg::PH_CMD) ? cmd_ack
        : (phase_reg == spd_pkg::PH_ADDR) || ((phase_reg == spd_pkg::PH_WDATA) && data_acc);

    // write buffer and commit control
    wire logic byte_end = scl_fall && (cnt_reg == 4'h8);
    wire logic buf_wr = byte_end && (phase_reg == spd_pkg::PH_WDATA)
        && (op_reg == spd_pkg::OP_MEM) && !wr_prot;
    wire logic commit = stop_det && (phase_reg == spd_pkg::PH_WDATA)
        && (cnt_reg == 4'h1) && data_ok_reg;
    wire logic [3:0] bidx = busy_cnt_reg[3:0];
    wire logic busy_done = busy_reg && (busy_cnt_reg == '0);
    wire logic commit_mem = busy_reg && (op_reg == spd_pkg::OP_MEM)
        && (busy_cnt_reg < BW'(spd_pkg::PAGE_BYTES)) && wmask_reg[bidx];
    wire logic [7:0] mem_rd = mem_arr[{page_reg, addr_reg}];

    // bus sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_reg <= spd_pkg::PH_IDLE;
            op_reg <= spd_pkg::OP_MEM;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            tx_reg <= 8'h00;
            addr_reg <= 8'h00;
            wbase_reg <= 5'h00;
            blk_reg <= 2'h0;
            wmask_reg <= 16'h0000;
            oe_reg <= 1'b0;
            page_reg <= 1'b0;
            data_ok_reg <= 1'b0;
            busy_reg <= 1'b0;
            busy_cnt_reg <= '0;
        end else if (busy_reg) begin
            busy_cnt_reg <= busy_cnt_reg - 1'b1;
            if (busy_done) begin
                busy_reg <= 1'b0;
                wmask_reg <= 16'h0000;
            end
        end else if (start_det) begin
            phase_reg <= spd_pkg::PH_CMD;
            cnt_reg <= 4'h0;
            oe_reg <= 1'b0;
            data_ok_reg <= 1'b0;
            wmask_reg <= 16'h0000;
        end else if (stop_det) begin
            phase_reg <= spd_pkg::PH_IDLE;
            cnt_reg <= 4'h0;
            oe_reg <= 1'b0;
            busy_reg <= commit;
            busy_cnt_reg <= BW'(WRITE_CYCLES - 1);
        end else if (phase_reg != spd_pkg::PH_IDLE) begin
            if (scl_rise) begin
                cnt_reg <= cnt_reg + 4'h1;
                if (cnt_reg < 4'h8) begin
                    sh_reg <= {sh_reg[6:0], sda_f};
                end
                // master nack ends the read
                if (phase_reg == spd_pkg::PH_RDATA && cnt_reg == 4'h8 && sda_f) begin
                    phase_reg <= spd_pkg::PH_SKIP;
                end
            end
            if (byte_end) begin
                oe_reg <= ack_now;
                case (phase_reg)
                    spd_pkg::PH_CMD: begin
                        phase_reg <= cmd_next;
                        op_reg <= c_pset ? spd_pkg::OP_PSET
                            : c_pclr ? spd_pkg::OP_PCLR : spd_pkg::OP_MEM;
                        blk_reg <= blk_idx;
                        if (c_plo) page_reg <= 1'b0;
                        if (c_phi) page_reg <= 1'b1;
                    end
                    spd_pkg::PH_ADDR: begin
                        phase_reg <= spd_pkg::PH_WDATA;
                        if (op_reg == spd_pkg::OP_MEM) begin
                            addr_reg <= sh_reg;
                            wbase_reg <= {page_reg, sh_reg[7:4]};
                        end
                    end
                    spd_pkg::PH_WDATA: begin
                        data_ok_reg <= data_acc;
                        if (buf_wr) begin
                            addr_reg[3:0] <= addr_reg[3:0] + 4'h1;
                            wmask_reg[addr_reg[3:0]] <= 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall && cnt_reg == 4'h9) begin
                cnt_reg <= 4'h0;
                if (phase_reg == spd_pkg::PH_RDATA) begin
                    tx_reg <= {mem_rd[6:0], 1'b0};
                    oe_reg <= !mem_rd[7];
                    addr_reg <= addr_reg + 8'h01;
                end else begin
                    oe_reg <= 1'b0;
                end
            end else if (scl_fall && phase_reg == spd_pkg::PH_RDATA && cnt_reg != 4'h0) begin
                oe_reg <= !tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
        end
    end

    // page buffer fill and array commit
    always_ff @(posedge aclk) begin
        if (buf_wr) begin
            wbuf[addr_reg[3:0]] <= sh_reg;
        end
        if (commit_mem) begin
            mem_arr[{wbase_reg, bidx}] <= wbuf[bidx];
        end
    end

    // protection bits survive reset; a committed set wins over erase
    always_ff @(posedge aclk) begin
        if (busy_done && op_reg == spd_pkg::OP_PSET) begin
            prot_reg[blk_reg] <= 1'b1;
        end else if (protect_erase || (busy_done && op_reg == spd_pkg::OP_PCLR)) begin
            prot_reg <= 4'h0;
        end
    end

    // outputs
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = oe_reg;
    assign write_busy = busy_reg;
    assign page_sel = page_reg;
endmodule : spd_dev
`default_nettype wire

/* spd_host.sv */
`timescale 1ns/100ps
`default_nettype none
module spd_host #(
    parameter int QUARTER = spd_pkg::QUARTER_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // two-wire link
    spd_if.host bus
);
    localparam int QW = $clog2(QUARTER + 1);

    if (QUARTER < 6) begin : g_bad_quarter
        $error("quarter bit too short for the device sampler");
    end

    logic [11:0] cmd_reg;
    logic [7:0] tx_reg, rx_reg;
    logic busy_reg, acked_reg, scl_reg, oe_reg;
    spd_pkg::spd_hstate_t st_reg;
    logic [1:0] step_reg;
    logic [3:0] bit_reg;
    logic [QW-1:0] tmr_reg;
    logic s1, s2, s3, sda_f;

    // data line sampling
    always_ff @(posedge aclk) begin
        s1 <= bus.sda;
        s2 <= s1;
        s3 <= s2;
        if (!aresetn) sda_f <= 1'b1;
        else if (s2 == s3) sda_f <= s3;
    end

    // register decode
    wire logic wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    wire logic wr_hit = (s_axi_awaddr == spd_pkg::CMD_OFS) || (s_axi_awaddr == spd_pkg::STATUS_OFS);
    wire logic wr_cmd = wr_go && (s_axi_awaddr == spd_pkg::CMD_OFS)
        && (s_axi_wstrb[1:0] == 2'h3) && !busy_reg;
    wire logic rd_go = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    wire logic rd_cmd = (s_axi_araddr == spd_pkg::CMD_OFS);
    wire logic rd_sts = (s_axi_araddr == spd_pkg::STATUS_OFS);
    wire logic [31:0] rd_val = rd_cmd ? {20'h00000, cmd_reg}
        : rd_sts ? {16'h0000, rx_reg, 6'h00, acked_reg, busy_reg} : 32'h00000000;
    wire logic tick = (tmr_reg == '0);
    wire logic is_rd = cmd_reg[spd_pkg::CMD_READ_BIT];

    // axi4-lite slave
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= spd_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= spd_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (wr_go) s_axi_bresp <= wr_hit ? spd_pkg::RESP_OKAY : spd_pkg::RESP_SLVERR;
            if (s_axi_awready) s_axi_bvalid <= 1'b1;
            else if (s_axi_bready) s_axi_bvalid <= 1'b0;
            s_axi_arready <= rd_go;
            if (rd_go) begin
                s_axi_rdata <= rd_val;
                s_axi_rresp <= (rd_cmd || rd_sts) ? spd_pkg::RESP_OKAY : spd_pkg::RESP_SLVERR;
            end
            if (s_axi_arready) s_axi_rvalid <= 1'b1;
            else if (s_axi_rready) s_axi_rvalid <= 1'b0;
        end
    end

    // link sequencer, quarter-bit steps
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_reg <= 12'h000;
            tx_reg <= 8'h00;
            rx_reg <= 8'h00;
            busy_reg <= 1'b0;
            acked_reg <= 1'b0;
            scl_reg <= 1'b1;
            oe_reg <= 1'b0;
            st_reg <= spd_pkg::H_IDLE;
            step_reg <= 2'h0;
            bit_reg <= 4'h0;
            tmr_reg <= '0;
        end else begin
            tmr_reg <= tick ? QW'(QUARTER - 1) : tmr_reg - 1'b1;
            if (wr_cmd) begin
                cmd_reg <= s_axi_wdata[11:0];
                tx_reg <= s_axi_wdata[7:0];
                busy_reg <= 1'b1;
                st_reg <= s_axi_wdata[spd_pkg::CMD_START_BIT] ? spd_pkg::H_START : spd_pkg::H_BIT;
                step_reg <= 2'h0;
                bit_reg <= 4'h0;
            end else if (busy_reg && tick) begin
                step_reg <= step_reg + 2'h1;
                case (st_reg)
                    spd_pkg::H_START: begin
                        case (step_reg)
                            2'h0: oe_reg <= 1'b0;
                            2'h1: scl_reg <= 1'b1;
                            2'h2: oe_reg <= 1'b1;
                            default: begin
                                scl_reg <= 1'b0;
                                st_reg <= spd_pkg::H_BIT;
                            end
                        endcase
                    end
                    spd_pkg::H_BIT: begin
                        case (step_reg)
                            2'h0: oe_reg <= bit_reg[3] ? (is_rd && cmd_reg[spd_pkg::CMD_MACK_BIT])
                                : (!is_rd && !tx_reg[7]);
                            2'h1: scl_reg <= 1'b1;
                            2'h2: begin
                                if (bit_reg[3]) acked_reg <= !sda_f;
                                else rx_reg <= {rx_reg[6:0], sda_f};
                            end
                            default: begin
                                scl_reg <= 1'b0;
                                tx_reg <= {tx_reg[6:0], 1'b0};
                                bit_reg <= bit_reg + 4'h1;
                                if (bit_reg[3]) begin
                                    busy_reg <= cmd_reg[spd_pkg::CMD_STOP_BIT];
                                    st_reg <= cmd_reg[spd_pkg::CMD_STOP_BIT] ? spd_pkg::H_STOP
                                        : spd_pkg::H_IDLE;
                                end
                            end
                        endcase
                    end
                    spd_pkg::H_STOP: begin
                        case (step_reg)
                            2'h0: oe_reg <= 1'b1;
                            2'h1: scl_reg <= 1'b1;
                            default: begin
                                oe_reg <= 1'b0;
                                busy_reg <= 1'b0;
                                st_reg <= spd_pkg::H_IDLE;
                            end
                        endcase
                    end
                    default: busy_reg <= 1'b0;
                endcase
            end
        end
    end

    // link outputs
    assign bus.scl = scl_reg;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_sda_oe = oe_reg;
endmodule : spd_host
`default_nettype wire

/* spd_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module spd_checker #(
    parameter int WRITE_CYCLES = 40
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link lines
    input wire logic scl,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic sda,
    // device status
    input wire logic write_busy,
    input wire logic page_sel
);
    logic [15:0] busy_cnt_reg;
    logic [15:0] busy_cnt_next;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // length of the running write cycle
    assign busy_cnt_next = write_busy ? busy_cnt_reg + 16'h1 : 16'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_cnt_reg <= 16'h0;
        end else begin
            busy_cnt_reg <= busy_cnt_next;
        end
    end

    busy_len_a: assert property (
        $fell(write_busy) |-> busy_cnt_reg == WRITE_CYCLES) else $error("write cycle length off");
    busy_quiet_a: assert property (
        write_busy |-> !dev_sda_oe) else $error("device drives data while busy");
    busy_stop_a: assert property (
        $rose(write_busy) |-> scl && sda) else $error("write cycle without stop");
    reset_idle_a: assert property (
        $rose(aresetn) |-> scl && !host_sda_oe && !dev_sda_oe && !page_sel && !write_busy)
        else $error("state after reset wrong");
    ack_launch_a: assert property (
        $rose(dev_sda_oe) |-> !scl) else $error("device pulls data with clock high");
    data_release_a: assert property (
        $fell(dev_sda_oe) |-> !scl) else $error("device releases data with clock high");
    page_move_a: assert property (
        $changed(page_sel) |-> !scl && !write_busy) else $error("page bit moved badly");
    wire_level_a: assert property (
        sda == !(host_sda_oe || dev_sda_oe)) else $error("data line level wrong");
endmodule : spd_checker
`default_nettype wire

/* spd_eeprom_serial_access_test.sv */
`timescale 1ns/100ps
`default_nettype none
module spd_eeprom_serial_access_test;
    typedef struct {
        string nm;
        logic [33:0] v;
        logic [33:0] m;
    } spd_exp_t;
    localparam int WC = 400;
    // probes: any level, ack expected, high voltage, select byte
    localparam logic [10:0] PROBE [9] = '{11'h062, 11'h136, 11'h164, 11'h669, 11'h66D,
        11'h66E, 11'h46D, 11'h66C, 11'h66D};
    logic aclk, aresetn, hv, erase, busy, page;
    logic awv, awr, wv, wr, bv, bry, arv, arr, rv, rry;
    logic [1:0] bresp, rresp;
    logic [2:0] sa;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd;
    logic [7:0] d [8];
    int error_cnt, comparisons;
    spd_exp_t expq [$];

    spd_if spd_if_i ();
    spd_dev #(.WRITE_CYCLES(WC)) spd_dev_i (.aclk(aclk), .aresetn(aresetn), .bus(spd_if_i),
        .sa_pins(sa), .sa0_high_voltage(hv), .protect_erase(erase), .write_busy(busy),
        .page_sel(page));
    spd_host #(.QUARTER(6)) spd_host_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .bus(spd_if_i));
    spd_checker #(.WRITE_CYCLES(WC)) spd_checker_i (.aclk(aclk), .aresetn(aresetn),
        .scl(spd_if_i.scl), .host_sda_oe(spd_if_i.host_sda_oe),
        .dev_sda_oe(spd_if_i.dev_sda_oe), .sda(spd_if_i.sda), .write_busy(busy),
        .page_sel(page));

    // clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // watchdog
    initial begin
        repeat (60000) @(posedge aclk);
        error_cnt++;
        summarize();
    end

    // compares each noted read result as it returns
    always @(posedge aclk) begin
        if (expq.size() > 0 && rv === 1'b1 && rry === 1'b1) begin
            chk(expq[0].nm, {rresp, rd} & expq[0].m, expq[0].v);
            expq.delete(0);
        end
    end

    task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        awa <= a;
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        // each channel released at its own ready
        do begin
            @(posedge aclk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wr === 1'b1) wv <= 1'b0;
        end while ((awv && awr !== 1'b1) || (wv && wr !== 1'b1));
        do @(posedge aclk); while (bv !== 1'b1);
        chk("bresp", {32'h0, bresp}, 34'h0);
        bry <= 1'b0;
        @(posedge aclk);
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] v);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge aclk); while (rv !== 1'b1);
        v = rd;
        rry <= 1'b0;
        @(posedge aclk);
    endtask : axr

    task automatic ck(input string nm, input logic [7:0] a, input logic [33:0] v,
        input logic [33:0] m);
        logic [31:0] s;
        expq.push_back('{nm, v, m});
        axr(a, s);
    endtask : ck

    // one byte on the link, then wait until the host is free
    task automatic job(input logic [11:0] c);
        logic [31:0] s;
        axw(8'h00, {20'h0, c});
        do axr(8'h04, s); while (s[0] !== 1'b0);
    endtask : job

    task automatic tx(input string nm, input logic [3:0] f, input logic [7:0] b, input logic e);
        job({f, b});
        ck(nm, 8'h04, {32'h0, e, 1'b0}, 34'h3);
    endtask : tx

    task automatic rx(input string nm, input logic [3:0] f, input logic [7:0] e);
        job({f | 4'h4, 8'h00});
        ck(nm, 8'h04, {24'h0, e, 8'h0}, 34'h0FF01);
    endtask : rx

    task automatic idle();
        repeat (8) @(posedge aclk);
        while (busy !== 1'b0) @(posedge aclk);
    endtask : idle

    task automatic rst();
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
    endtask : rst

    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    initial begin
        void'($urandom(32'hFB4D));
        {aresetn, awv, wv, bry, arv, rry, hv, erase} = 8'h0;
        {awa, ara, wd} = 48'h0;
        sa = 3'($urandom());
        foreach (d[i]) d[i] = 8'($urandom());
        rst();
        erase <= 1'b1;
        @(posedge aclk);
        erase <= 1'b0;
        // single select bytes, each closed by a stop
        for (int i = 0; i < 9; i++) begin
            hv <= PROBE[i][10] ? 1'($urandom()) : PROBE[i][8];
            @(posedge aclk);
            tx("probe", 4'h3, PROBE[i][7:0], PROBE[i][9]);
        end
        tx("wrong sel", 4'h3, {4'hA, ~sa, 1'b0}, 1'b0);
        $display("test select probes done");
        // page write wrapping at the page end, polling, reads
        tx("wr sel", 4'h1, {4'hA, sa, 1'b0}, 1'b1);
        tx("wr addr", 4'h0, 8'h1C, 1'b1);
        for (int i = 0; i < 8; i++) begin
            tx("wr data", i == 7 ? 4'h2 : 4'h0, d[i], 1'b1);
        end
        tx("poll busy", 4'h3, {4'hA, sa, 1'b0}, 1'b0);
        idle();
        tx("poll done", 4'h1, {4'hA, sa, 1'b0}, 1'b1);
        tx("rd addr", 4'h0, 8'h10, 1'b1);
        tx("rd sel", 4'h1, {4'hA, sa, 1'b1}, 1'b1);
        rx("rand rd", 4'h2, d[4]);
        tx("cur sel", 4'h1, {4'hA, sa, 1'b1}, 1'b1);
        rx("cur rd", 4'h2, d[5]);
        $display("test page write done");
        // protect block 0, refused write, clear
        hv <= 1'b1;
        tx("set sel", 4'h1, 8'h62, 1'b1);
        tx("set addr", 4'h0, 8'h00, 1'b1);
        tx("set data", 4'h2, 8'h00, 1'b1);
        idle();
        tx("query 0", 4'h3, 8'h63, 1'b0);
        tx("query 1", 4'h3, 8'h69, 1'b1);
        tx("prot sel", 4'h1, {4'hA, sa, 1'b0}, 1'b1);
        tx("prot addr", 4'h0, 8'h10, 1'b1);
        tx("prot data", 4'h2, ~d[4], 1'b0);
        chk("no write", {33'h0, busy}, 34'h0);
        tx("cur sel", 4'h1, {4'hA, sa, 1'b1}, 1'b1);
        rx("cur rd", 4'h2, d[4]);
        tx("clr sel", 4'h1, 8'h66, 1'b1);
        tx("clr addr", 4'h0, 8'h00, 1'b1);
        tx("clr data", 4'h2, 8'h00, 1'b1);
        idle();
        tx("query 0", 4'h3, 8'h63, 1'b1);
        ck("cmd reg", 8'h00, {22'h0, 12'h363}, {34{1'b1}});
        ck("unmapped", 8'h08, {spd_pkg::RESP_SLVERR, 32'h0}, {34{1'b1}});
        $display("test protection done");
        // upper half write, then reset returns to the lower half
        hv <= 1'b0;
        tx("page hi", 4'h3, 8'h6E, 1'b1);
        chk("page bit", {33'h0, page}, 34'h1);
        tx("p1 sel", 4'h1, {4'hA, sa, 1'b0}, 1'b1);
        tx("p1 addr", 4'h0, 8'h10, 1'b1);
        tx("p1 data", 4'h2, ~d[4], 1'b1);
        idle();
        rst();
        tx("a sel", 4'h1, {4'hA, sa, 1'b0}, 1'b1);
        tx("a addr", 4'h0, 8'h10, 1'b1);
        tx("b sel", 4'h1, {4'hA, sa, 1'b1}, 1'b1);
        rx("page 0 rd", 4'h2, d[4]);
        $display("test page reset done");
        summarize();
    end
endmodule : spd_eeprom_serial_access_test
`default_nettype wire
